//--- rtl/lmr_pkg.sv
package lmr_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_POWER_POINTER = 8'h4c;
  localparam logic [7:0] IDX_LINE_POWER    = 8'h4d;
  localparam logic [7:0] IDX_LOOP_VOLTAGE  = 8'h4e;
  localparam logic [7:0] IDX_LOOP_CURRENT  = 8'h4f;
  localparam logic [7:0] IDX_TIP_VOLTAGE   = 8'h50;
  localparam logic [7:0] IDX_RING_VOLTAGE  = 8'h51;
  localparam logic [7:0] IDX_BATTERY_A     = 8'h52;
  localparam logic [7:0] IDX_BATTERY_B     = 8'h53;

  localparam int ADDR_W = 10;

  // field positions
  localparam int SIGN_BIT = 6;
  localparam int MAG_MSB  = 5;
  localparam int PTR_MSB  = 2;

  // values after reset
  localparam logic [2:0] RST_POWER_POINTER = 3'h0;
  localparam logic [7:0] RST_CODE          = 8'h00;

  // pointer codes; 3'h6 and 3'h7 select nothing
  localparam logic [2:0] PTR_LAST_VALID = 3'h5;
  localparam int         NUM_TRANSISTOR = 6;

  // cycles an input must hold before it shows in a register
  localparam int SETTLE_CYCLES = 3;

  // code weights, carried for software: one step of each code
  localparam int POWER_STEP_HI_UW   = 30400;
  localparam int POWER_STEP_LO_UW   = 3620;
  localparam int LOOP_V_STEP_MV     = 1500;
  localparam int LOOP_I_STEP_UA     = 1250;
  localparam int GROUND_V_STEP_MV   = 376;

  typedef struct packed {
    logic [NUM_TRANSISTOR-1:0][7:0] line_power_value;
    logic                           loop_voltage_sign;
    logic [5:0]                     loop_voltage_magnitude;
    logic                           loop_current_sign;
    logic [5:0]                     loop_current_magnitude;
    logic [7:0]                     tip_voltage_code;
    logic [7:0]                     ring_voltage_code;
    logic [7:0]                     battery_voltage_code;
  } lmr_meas_t;

endpackage : lmr_pkg

//--- rtl/lmr_word_sync.sv
`timescale 1ns/100ps
module lmr_word_sync
  import lmr_pkg::*;
#(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // word from another domain, and its settled copy
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  // a word is taken only once it reads the same twice, so a half-changed
  // multi-bit sample never reaches software
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      q      <= '0;
    end else begin
      stage1 <= d;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        q <= stage2;
      end
    end
  end

endmodule : lmr_word_sync

//--- rtl/lmr_power_sel.sv
`timescale 1ns/100ps
module lmr_power_sel
  import lmr_pkg::*;
(
  // selection
  input  wire logic [2:0]                     pointer,
  input  wire logic [NUM_TRANSISTOR-1:0][7:0] power,
  // selected code
  output logic      [7:0]                     value
);

  always_comb begin
    unique case (pointer)
      3'h0: value = power[0];
      3'h1: value = power[1];
      3'h2: value = power[2];
      3'h3: value = power[3];
      3'h4: value = power[4];
      3'h5: value = power[5];
      // undefined pointer codes read as zero rather than stale data
      default: value = RST_CODE;
    endcase
  end

endmodule : lmr_power_sel

//--- rtl/lmr_line_monitor.sv
`timescale 1ns/100ps
// Summary of operation
// - power register reads pointer-selected transistor power
// - transistors 1,2,5,6 code at 30.4 mW
// - transistors 3,4 code at 3.62 mW
// - loop voltage sign in bit 6
// - loop voltage magnitude in bits 5:0
// - loop current direction in bit 6
// - loop current magnitude in bits 5:0
// - tip voltage code, 0.376 V steps
// - ring voltage code, same scale as tip
// - battery voltage readable from two registers
// - pointer codes 0-5 select transistors 1-6
module lmr_line_monitor
  import lmr_pkg::*;
(
  // apb clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb request
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  // apb answer
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // measurement front end, not on pclk
  input  wire lmr_meas_t         meas_in
);

  localparam logic [ADDR_W-1:0] A_PTR  = {IDX_POWER_POINTER, 2'b00};
  localparam logic [ADDR_W-1:0] A_PWR  = {IDX_LINE_POWER, 2'b00};
  localparam logic [ADDR_W-1:0] A_LV   = {IDX_LOOP_VOLTAGE, 2'b00};
  localparam logic [ADDR_W-1:0] A_LC   = {IDX_LOOP_CURRENT, 2'b00};
  localparam logic [ADDR_W-1:0] A_TIP  = {IDX_TIP_VOLTAGE, 2'b00};
  localparam logic [ADDR_W-1:0] A_RING = {IDX_RING_VOLTAGE, 2'b00};
  localparam logic [ADDR_W-1:0] A_BATA = {IDX_BATTERY_A, 2'b00};
  localparam logic [ADDR_W-1:0] A_BATB = {IDX_BATTERY_B, 2'b00};

  logic [$bits(lmr_meas_t)-1:0] meas_bits;
  lmr_meas_t                    meas;
  logic [2:0]                   power_pointer;
  logic [7:0]                   line_power_value;

  logic        setup;
  logic        access;
  logic        hit_ptr;
  logic        hit_pwr;
  logic        hit_lv;
  logic        hit_lc;
  logic        hit_tip;
  logic        hit_ring;
  logic        hit_bata;
  logic        hit_batb;
  logic        hit_ro;
  logic        hit_any;
  logic        ptr_write;
  logic [31:0] rd_word;

  // front end words cross into pclk before anything reads them
  lmr_word_sync #(
    .W ($bits(lmr_meas_t))
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (meas_in),
    .q     (meas_bits)
  );

  assign meas = meas_bits;

  lmr_power_sel u_power_sel (
    .pointer (power_pointer),
    .power   (meas.line_power_value),
    .value   (line_power_value)
  );

  // decode
  assign setup    = psel & ~penable;
  assign access   = psel & penable;
  assign hit_ptr  = (paddr == A_PTR);
  assign hit_pwr  = (paddr == A_PWR);
  assign hit_lv   = (paddr == A_LV);
  assign hit_lc   = (paddr == A_LC);
  assign hit_tip  = (paddr == A_TIP);
  assign hit_ring = (paddr == A_RING);
  assign hit_bata = (paddr == A_BATA);
  assign hit_batb = (paddr == A_BATB);
  assign hit_ro   = hit_pwr | hit_lv | hit_lc | hit_tip | hit_ring | hit_bata | hit_batb;
  assign hit_any  = hit_ro | hit_ptr;

  // only the pointer takes writes; writes to monitors fall on the floor
  assign ptr_write = access & pwrite & hit_ptr & pstrb[0];

  // read selection; bit 7 of the loop registers is reserved and reads zero
  assign rd_word =
    hit_ptr  ? {29'h0, power_pointer} :
    hit_pwr  ? {24'h0, line_power_value} :
    hit_lv   ? {24'h0, 1'b0, meas.loop_voltage_sign,
                meas.loop_voltage_magnitude} :
    hit_lc   ? {24'h0, 1'b0, meas.loop_current_sign,
                meas.loop_current_magnitude} :
    hit_tip  ? {24'h0, meas.tip_voltage_code} :
    hit_ring ? {24'h0, meas.ring_voltage_code} :
    hit_bata ? {24'h0, meas.battery_voltage_code} :
    hit_batb ? {24'h0, meas.battery_voltage_code} :
    32'h0;

  // zero wait states: data is latched in setup, shown through access
  assign pready  = access;
  assign pslverr = access & ~hit_any;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_pointer <= RST_POWER_POINTER;
    end else if (ptr_write) begin
      power_pointer <= pwdata[PTR_MSB:0];
    end
  end

  // a read snapshots the measurement once, so it cannot tear mid-access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (setup & ~pwrite) begin
      prdata <= rd_word;
    end
  end

  // ---- checks ----

  logic                         rd_setup;
  logic [$bits(lmr_meas_t)-1:0] in_s1;
  logic [$bits(lmr_meas_t)-1:0] in_s2;
  logic [$bits(lmr_meas_t)-1:0] last_in;
  logic [2:0]                   hold_cnt;

  assign rd_setup = setup & ~pwrite;

  // counts how long the front end word has held still; the word is
  // re-timed through two flops first, as it is not on pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_s1    <= '0;
      in_s2    <= '0;
      last_in  <= '0;
      hold_cnt <= 3'h0;
    end else begin
      in_s1   <= meas_in;
      in_s2   <= in_s1;
      last_in <= in_s2;
      if (in_s2 != last_in) begin
        hold_cnt <= 3'h0;
      end else if (hold_cnt != 3'h7) begin
        hold_cnt <= hold_cnt + 3'h1;
      end
    end
  end

  property p_power_follows_pointer;
    @(posedge pclk) disable iff (!presetn)
      rd_setup && hit_pwr && (power_pointer <= PTR_LAST_VALID)
      |=> prdata[7:0] == $past(meas.line_power_value[power_pointer]);
  endproperty
  a_power_follows_pointer: assert property (p_power_follows_pointer)
    else $error("power read does not match selected transistor");

  property p_power_high_range;
    @(posedge pclk) disable iff (!presetn)
      rd_setup && hit_pwr &&
      (power_pointer inside {3'h0, 3'h1, 3'h4, 3'h5})
      |=> prdata == {24'h0, $past(meas.line_power_value[power_pointer])};
  endproperty
  a_power_high_range: assert property (p_power_high_range)
    else $error("power read wrong for high range transistor");

  property p_power_low_range;
    @(posedge pclk) disable iff (!presetn)
      rd_setup && hit_pwr && (power_pointer inside {3'h2, 3'h3})
      |=> prdata == {24'h0, $past(meas.line_power_value[power_pointer])};
  endproperty
  a_power_low_range: assert property (p_power_low_range)
    else $error("power read wrong for low range transistor");

  property p_loop_voltage_sign;
    @(posedge pclk) disable iff (!presetn)
      rd_setup && hit_lv
      |=> (prdata[SIGN_BIT] == $past(meas.loop_voltage_sign))
          && (prdata[31:7] == 25'h0);
  endproperty
  a_loop_voltage_sign: assert property (p_loop_voltage_sign)
    else $error("loop voltage sign bit wrong");

  property p_loop_voltage_mag;
    @(posedge pclk) disable iff (!presetn)
      rd_setup && hit_lv
      |=> prdata[MAG_MSB:0] == $past(meas.loop_voltage_magnitude);
  endproperty
  a_loop_voltage_mag: assert property (p_loop_voltage_mag)
    else $error("loop voltage magnitude wrong");

  property p_loop_current_sign;
    @(posedge pclk) disable iff (!presetn)
      rd_setup && hit_lc
      |=> (prdata[SIGN_BIT] == $past(meas.loop_current_sign))
          && (prdata[31:7] == 25'h0);
  endproperty
  a_loop_current_sign: assert property (p_loop_current_sign)
    else $error("loop current direction bit wrong");

  property p_loop_current_mag;
    @(posedge pclk) disable iff (!presetn)
      rd_setup && hit_lc
      |=> prdata[MAG_MSB:0] == $past(meas.loop_current_magnitude);
  endproperty
  a_loop_current_mag: assert property (p_loop_current_mag)
    else $error("loop current magnitude wrong");

  property p_tip_code;
    @(posedge pclk) disable iff (!presetn)
      rd_setup && hit_tip
      |=> prdata == {24'h0, $past(meas.tip_voltage_code)};
  endproperty
  a_tip_code: assert property (p_tip_code)
    else $error("tip voltage read wrong");

  property p_ring_code;
    @(posedge pclk) disable iff (!presetn)
      rd_setup && hit_ring
      |=> prdata == {24'h0, $past(meas.ring_voltage_code)};
  endproperty
  a_ring_code: assert property (p_ring_code)
    else $error("ring voltage read wrong");

  property p_battery_mirror;
    @(posedge pclk) disable iff (!presetn)
      rd_setup && (hit_bata || hit_batb)
      |=> prdata == {24'h0, $past(meas.battery_voltage_code)};
  endproperty
  a_battery_mirror: assert property (p_battery_mirror)
    else $error("battery voltage read wrong");

  property p_pointer_write;
    @(posedge pclk) disable iff (!presetn)
      access && pwrite && hit_ptr && pstrb[0]
      |=> power_pointer == $past(pwdata[PTR_MSB:0]);
  endproperty
  a_pointer_write: assert property (p_pointer_write)
    else $error("pointer write not taken");

  property p_monitor_write_ignored;
    @(posedge pclk) disable iff (!presetn)
      access && pwrite && hit_ro
      |-> !pslverr && pready ##1 $stable(power_pointer) && $stable(prdata);
  endproperty
  a_monitor_write_ignored: assert property (p_monitor_write_ignored)
    else $error("write to monitor register had an effect");

  property p_values_track;
    @(posedge pclk) disable iff (!presetn)
      hold_cnt >= SETTLE_CYCLES |-> meas_bits == last_in;
  endproperty
  a_values_track: assert property (p_values_track)
    else $error("monitor value failed to follow the front end");

  property p_unmapped_error;
    @(posedge pclk) disable iff (!presetn)
      rd_setup && !hit_any |=> prdata == 32'h0 && pslverr && pready;
  endproperty
  a_unmapped_error: assert property (p_unmapped_error)
    else $error("unmapped read not answered with zero and error");

  property p_pointer_strobe_masked;
    @(posedge pclk) disable iff (!presetn)
      access && pwrite && hit_ptr && !pstrb[0]
      |=> $stable(power_pointer);
  endproperty
  a_pointer_strobe_masked: assert property (p_pointer_strobe_masked)
    else $error("pointer changed by a write without its byte strobe");

  property p_power_undefined_zero;
    @(posedge pclk) disable iff (!presetn)
      rd_setup && hit_pwr && (power_pointer > PTR_LAST_VALID)
      |=> prdata == 32'h0;
  endproperty
  a_power_undefined_zero: assert property (p_power_undefined_zero)
    else $error("power read with undefined pointer not zero");

  property p_pointer_readback;
    @(posedge pclk) disable iff (!presetn)
      rd_setup && hit_ptr
      |=> prdata == {29'h0, $past(power_pointer)};
  endproperty
  a_pointer_readback: assert property (p_pointer_readback)
    else $error("pointer read back wrong");

  property p_read_data_holds;
    @(posedge pclk) disable iff (!presetn)
      !rd_setup
      |=> $stable(prdata);
  endproperty
  a_read_data_holds: assert property (p_read_data_holds)
    else $error("read data changed outside a read setup");

  property p_monitor_upper_zero;
    @(posedge pclk) disable iff (!presetn)
      rd_setup && hit_ro
      |=> prdata[31:8] == 24'h0;
  endproperty
  a_monitor_upper_zero: assert property (p_monitor_upper_zero)
    else $error("monitor read has upper bits set");

  property p_pointer_no_error;
    @(posedge pclk) disable iff (!presetn)
      access && hit_ptr
      |-> pready && !pslverr;
  endproperty
  a_pointer_no_error: assert property (p_pointer_no_error)
    else $error("pointer access answered with error");

  property p_monitor_changes_settled;
    @(posedge pclk) disable iff (!presetn)
      !$stable(meas_bits)
      |-> meas_bits == last_in;
  endproperty
  a_monitor_changes_settled: assert property (p_monitor_changes_settled)
    else $error("monitor took a word that had not settled");

  property p_zero_wait;
    @(posedge pclk) disable iff (!presetn)
      setup
      |=> pready;
  endproperty
  a_zero_wait: assert property (p_zero_wait)
    else $error("access phase not answered at once");

endmodule : lmr_line_monitor

//--- dv/lmr_line_monitor_bench.sv
`timescale 1ns/100ps
module lmr_line_monitor_bench
  import lmr_pkg::*;
;
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [3:0]        pstrb;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  lmr_meas_t         meas_in;
  logic [2:0]        ptr;
  logic [31:0]       rdat;
  logic              rerr;
  int                failures;
  int                n_compared;

  lmr_line_monitor u_lmr_line_monitor (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pstrb   (pstrb),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .meas_in (meas_in)
  );

  always #50 pclk = ~pclk;

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // entered just after a rising edge; leaves one idle cycle so psel is never assigned twice
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     input logic [3:0] st, output logic [31:0] rd, output logic err);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ADDR_W'({idx, 2'b00});
    pwdata  <= wd;
    pstrb   <= st;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    check("access cycles", 32'(n), 32'h1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // expected register content worked out from what the bench drives
  function automatic logic [31:0] exp_of(input logic [7:0] idx);
    case (idx)
      IDX_POWER_POINTER: return {29'h0, ptr};
      IDX_LINE_POWER:    return (ptr <= PTR_LAST_VALID) ? {24'h0, meas_in.line_power_value[ptr]}
                                                        : 32'h0;
      IDX_LOOP_VOLTAGE:  return {25'h0, meas_in.loop_voltage_sign, meas_in.loop_voltage_magnitude};
      IDX_LOOP_CURRENT:  return {25'h0, meas_in.loop_current_sign, meas_in.loop_current_magnitude};
      IDX_TIP_VOLTAGE:   return {24'h0, meas_in.tip_voltage_code};
      IDX_RING_VOLTAGE:  return {24'h0, meas_in.ring_voltage_code};
      default:           return {24'h0, meas_in.battery_voltage_code};
    endcase
  endfunction : exp_of

  task automatic rd_chk(input string what, input logic [7:0] idx);
    apb(1'b0, idx, 32'h0, 4'h0, rdat, rerr);
    check(what, rdat, exp_of(idx));
    check({what, " slverr"}, {31'h0, rerr}, 32'h0);
  endtask : rd_chk

  task automatic read_all(input string what);
    for (int i = IDX_POWER_POINTER; i <= IDX_BATTERY_B; i++) begin
      rd_chk(what, 8'(i));
    end
  endtask : read_all

  // front end needs several stable edges before a value shows
  task automatic settle();
    repeat (SETTLE_CYCLES + 6) @(posedge pclk);
  endtask : settle

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    meas_in = '0;
    ptr = 3'h0;
    failures = 0;
    n_compared = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    read_all("reset value");
    $display("test reset done");

    for (int i = 0; i < NUM_TRANSISTOR; i++) begin
      meas_in.line_power_value[i] <= 8'(8'h21 * (i + 1));
    end
    meas_in.line_power_value[5] <= 8'hff;
    meas_in.loop_voltage_sign <= 1'b1;
    meas_in.loop_voltage_magnitude <= 6'h3f;
    meas_in.loop_current_sign <= 1'b0;
    meas_in.loop_current_magnitude <= 6'h2a;
    meas_in.tip_voltage_code <= 8'hff;
    meas_in.ring_voltage_code <= 8'h5c;
    meas_in.battery_voltage_code <= 8'h81;
    settle();
    read_all("monitor set one");
    meas_in.loop_voltage_sign <= 1'b0;
    meas_in.loop_voltage_magnitude <= 6'h01;
    meas_in.loop_current_sign <= 1'b1;
    meas_in.loop_current_magnitude <= 6'h3f;
    meas_in.battery_voltage_code <= 8'h00;
    settle();
    read_all("monitor set two");
    $display("test monitors done");

    for (int p = 0; p < 8; p++) begin
      apb(1'b1, IDX_POWER_POINTER, 32'(p), 4'h1, rdat, rerr);
      check("pointer write slverr", {31'h0, rerr}, 32'h0);
      ptr = 3'(p);
      rd_chk("pointer", IDX_POWER_POINTER);
      rd_chk("line power", IDX_LINE_POWER);
    end
    apb(1'b1, IDX_POWER_POINTER, 32'h2, 4'he, rdat, rerr);
    rd_chk("pointer no strobe", IDX_POWER_POINTER);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    ptr = RST_POWER_POINTER;
    rd_chk("pointer after reset", IDX_POWER_POINTER);
    apb(1'b1, IDX_POWER_POINTER, 32'h2, 4'h1, rdat, rerr);
    ptr = 3'h2;
    rd_chk("power third", IDX_LINE_POWER);
    $display("test pointer done");

    for (int i = IDX_LINE_POWER; i <= IDX_BATTERY_B; i++) begin
      apb(1'b1, 8'(i), 32'hffffffff, 4'hf, rdat, rerr);
      check("write slverr", {31'h0, rerr}, 32'h0);
    end
    read_all("after writes");
    meas_in.tip_voltage_code <= 8'h3c;
    meas_in.line_power_value[2] <= 8'h07;
    settle();
    read_all("still updating");
    $display("test writes done");

    apb(1'b0, 8'h60, 32'h0, 4'h0, rdat, rerr);
    check("unmapped read data", rdat, 32'h0);
    check("unmapped read slverr", {31'h0, rerr}, 32'h1);
    apb(1'b1, 8'h4b, 32'h5, 4'h1, rdat, rerr);
    check("unmapped write slverr", {31'h0, rerr}, 32'h1);
    read_all("after unmapped");
    $display("test unmapped done");
    end_of_test();
  end

  initial begin
    repeat (3000) @(posedge pclk);
    failures++;
    end_of_test();
  end
endmodule : lmr_line_monitor_bench
